// file: ppq_pkg.sv
// Package for the pulse, period and quadrature capture block.
// Assumes a single 100 MHz system clock and a plain register port.
package ppq_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ            = 100_000_000;
  localparam int TICK_NS           = 1000;
  localparam int CYCLES_PER_US     = (CLK_HZ / 1_000_000) * TICK_NS / 1000;
  localparam int DEBOUNCE_US       = 1000;
  localparam int DEBOUNCE_CYCLES   = DEBOUNCE_US * CYCLES_PER_US;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SCAN    = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_MASK    = 8'h0C;
  localparam logic [7:0] REG_QNET    = 8'h10;
  localparam logic [7:0] REG_QFWD    = 8'h14;
  localparam logic [7:0] REG_QREV    = 8'h18;
  localparam logic [7:0] REG_QDIR    = 8'h1C;
  localparam logic [7:0] REG_PERIOD  = 8'h20;
  localparam logic [7:0] REG_PCOUNT  = 8'h24;
  localparam logic [7:0] REG_ITVL    = 8'h28;
  localparam logic [7:0] REG_CH_BASE = 8'h40;

  // ----------------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------------
  localparam int CTRL_EDGE_POS  = 0;
  localparam int CTRL_SW_POS    = 4;
  localparam int CTRL_QMODE_POS = 8;
  localparam int CTRL_OUT_POS   = 12;
  localparam int CTRL_PSEL_POS  = 16;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] ITVL_RESET  = 32'h0000_0001;

  // Status bits
  localparam int ST_SCAN   = 0;
  localparam int ST_OVF    = 1;
  localparam int ST_PERIOD = 2;
  localparam int ST_W      = 3;

  typedef enum logic [1:0] {
    Q_SINGLE,
    Q_DOUBLE,
    Q_QUAD
  } qmode_t;

  typedef enum logic [1:0] {
    OUT_COUNT,
    OUT_FREQ,
    OUT_AVG
  } out_sel_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage

// file: pulse_period_quadrature_counter.sv
// Pulse accumulators, period timer and quadrature decoder with registers.
// Assumes inputs synchronous-to-clock levels, one clock, software scans.
//
// Overview of operation
// - Period unit times rising edges with a microsecond base; reports us or Hz.
// - Period unit samples only while a scan is active.
// - Pulse accumulators count at all times, also between scans.
// - One event per detected transition, rising or falling as configured.
// - Each channel offers counts, frequency, or running average frequency.
// - Switch mode debounces so each closure gives exactly one count.
// - Debounce keeps switch rate below the high-frequency rate.
// - Quadrature count rises when A leads B, falls when B leads.
// - Quadrature reports net count, last step direction and separate forward and reverse tallies.
// - Single mode: up on A rising when A leads, down on A falling when B leads.
// - Double mode: count both edges of A, signed by direction.
// - Quad mode: count every edge of both phases, signed by direction.
// - Each pulse channel has a 32-bit counter, one count resolution.
// - Scan start captures each counter then restarts it, counting an edge in that cycle.
// - Counter reaching all ones is flagged as overflow unless an overflow was captured at the last scan start.
// - Frequency is captured count divided by the scan interval.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module pulse_period_quadrature_counter
  import ppq_pkg::*;
#(
  parameter int N_CH            = 4,
  parameter int DEBOUNCE_CNT    = DEBOUNCE_CYCLES
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic [N_CH-1:0]   single_ended_inputs,
  input  wire logic              enc_a,
  input  wire logic              enc_b,
  input  wire reg_req_t          reg_req,
  output      logic [31:0]       reg_rdata,
  output      logic              irq
);

  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  localparam int NI = N_CH + 2;
  // Pulse lines idle high, encoder phases idle low: no false edge at reset
  localparam logic [NI-1:0] IDLE_LVL = {2'b00, {N_CH{1'b1}}};
  logic [NI-1:0] sync1;
  logic [NI-1:0] sync2;
  logic [NI-1:0] prev;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= IDLE_LVL;
      sync2 <= IDLE_LVL;
      prev  <= IDLE_LVL;
    end else begin
      sync1 <= {enc_b, enc_a, single_ended_inputs};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0]     ctrl;
  logic [31:0]     itvl;
  logic [ST_W-1:0] status;
  logic [ST_W-1:0] mask;
  logic [ST_W-1:0] events;
  logic            scan_start;
  logic            scan_active;
  logic [N_CH-1:0] edge_cfg;
  logic [N_CH-1:0] sw_cfg;
  qmode_t          qmode;
  out_sel_t        out_sel;
  logic [1:0]      psel;

  assign edge_cfg = ctrl[CTRL_EDGE_POS +: N_CH];
  assign sw_cfg   = ctrl[CTRL_SW_POS +: N_CH];
  assign qmode    = qmode_t'(ctrl[CTRL_QMODE_POS +: 2]);
  assign out_sel  = out_sel_t'(ctrl[CTRL_OUT_POS +: 2]);
  assign psel     = ctrl[CTRL_PSEL_POS +: 2];

  // Writing bit 0 of SCAN starts a scan; bit 1 ends the period window
  assign scan_start = reg_req.wr && reg_req.addr == REG_SCAN
                      && reg_req.wdata[0];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      itvl <= ITVL_RESET;
      mask <= '0;
    end else if (reg_req.wr) begin
      if (reg_req.addr == REG_CTRL)
        ctrl <= reg_req.wdata;
      if (reg_req.addr == REG_ITVL && reg_req.wdata != 32'h0000_0000)
        itvl <= reg_req.wdata;
      if (reg_req.addr == REG_MASK)
        mask <= reg_req.wdata[ST_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_active <= 1'b0;
    end else if (scan_start) begin
      scan_active <= 1'b1;
    end else if (reg_req.wr && reg_req.addr == REG_SCAN
                 && reg_req.wdata[1]) begin
      scan_active <= 1'b0;
    end
  end

  // Set wins over write-one-to-clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      if (reg_req.wr && reg_req.addr == REG_STATUS)
        status <= (status & ~reg_req.wdata[ST_W-1:0]) | events;
      else
        status <= status | events;
    end
  end

  assign irq = |(status & mask);

  // ----------------------------------------------------------------------
  // Pulse channels
  // ----------------------------------------------------------------------
  logic [N_CH-1:0] ev;
  logic [N_CH-1:0] ovf;
  logic [31:0]     cnt [N_CH];
  logic [31:0]     cap [N_CH];
  logic [31:0]     freq [N_CH];
  logic [31:0]     avg [N_CH];

  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      logic        db_level;
      logic [31:0] db_cnt;
      logic        hf_ev;
      logic        sw_ev;
      logic        done_cap;

      // Edge select: 1 = rising, 0 = falling
      assign hf_ev = edge_cfg[g] ? (sync2[g] & ~prev[g])
                                 : (~sync2[g] & prev[g]);

      // Switch closure pulls low; a level held DEBOUNCE_CNT cycles is taken
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          db_level <= 1'b1;
          db_cnt   <= '0;
        end else if (sync2[g] == db_level) begin
          db_cnt <= '0;
        end else if (db_cnt == 32'(DEBOUNCE_CNT - 1)) begin
          db_level <= sync2[g];
          db_cnt   <= '0;
        end else begin
          db_cnt <= db_cnt + 32'h0000_0001;
        end
      end

      assign sw_ev = db_cnt == 32'(DEBOUNCE_CNT - 1)
                     && sync2[g] != db_level && !sync2[g];
      assign ev[g] = sw_cfg[g] ? sw_ev : hf_ev;

      // Counts always; on scan start capture and restart with this edge
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt[g]   <= '0;
          cap[g]   <= '0;
          ovf[g]   <= 1'b0;
          done_cap <= 1'b0;
        end else if (scan_start) begin
          cap[g]   <= cnt[g];
          cnt[g]   <= {31'h0000_0000, ev[g]};
          ovf[g]   <= 1'b0;
          done_cap <= 1'b1;
        end else begin
          done_cap <= 1'b0;
          if (ev[g])
            cnt[g] <= cnt[g] + 32'h0000_0001;
          if (cnt[g] == 32'hFFFF_FFFF)
            ovf[g] <= 1'b1;
        end
      end

      // Frequency one cycle after capture; running average of the two
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          freq[g] <= '0;
          avg[g]  <= '0;
        end else if (done_cap && !scan_start) begin
          freq[g] <= cap[g] / itvl;
          avg[g]  <= 32'((33'(avg[g]) + 33'(cap[g] / itvl)) >> 1);
        end
      end
    end
  endgenerate

  // Overflow flag held per capture for each channel
  logic [N_CH-1:0] cap_ovf;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      cap_ovf <= '0;
    else if (scan_start)
      cap_ovf <= ovf;
  end

  // ----------------------------------------------------------------------
  // Quadrature decoder
  // ----------------------------------------------------------------------
  logic        a_now;
  logic        b_now;
  logic        a_was;
  logic        b_was;
  logic        a_rise;
  logic        a_fall;
  logic        b_chg;
  logic        q_up;
  logic        q_dn;
  logic        q_dir;
  logic [31:0] q_net;
  logic [31:0] q_fwd;
  logic [31:0] q_rev;

  assign a_now  = sync2[N_CH];
  assign b_now  = sync2[N_CH+1];
  assign a_was  = prev[N_CH];
  assign b_was  = prev[N_CH+1];
  assign a_rise = a_now & ~a_was;
  assign a_fall = ~a_now & a_was;
  assign b_chg  = b_now ^ b_was;

  // A leads B: on an A edge, A and B differ afterwards when A rose with B low
  always_comb begin
    q_up = 1'b0;
    q_dn = 1'b0;
    case (qmode)
      Q_SINGLE: begin
        q_up = a_rise & ~b_now;
        q_dn = a_fall & ~b_now;
      end
      Q_DOUBLE: begin
        q_up = (a_rise | a_fall) & (a_now ^ b_now);
        q_dn = (a_rise | a_fall) & ~(a_now ^ b_now);
      end
      Q_QUAD: begin
        q_up = (a_rise | a_fall) & (a_now ^ b_now)
               | b_chg & ~(a_now ^ b_now);
        q_dn = (a_rise | a_fall) & ~(a_now ^ b_now)
               | b_chg & (a_now ^ b_now);
      end
      default: begin
        q_up = 1'b0;
        q_dn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_net <= '0;
      q_fwd <= '0;
      q_rev <= '0;
      q_dir <= 1'b0;
    end else if (scan_start) begin
      q_net <= '0;
      q_fwd <= '0;
      q_rev <= '0;
    end else if (q_up && !q_dn) begin
      q_net <= q_net + 32'h0000_0001;
      q_fwd <= q_fwd + 32'h0000_0001;
      q_dir <= 1'b1;
    end else if (q_dn && !q_up) begin
      q_net <= q_net - 32'h0000_0001;
      q_rev <= q_rev + 32'h0000_0001;
      q_dir <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Period timer
  // ----------------------------------------------------------------------
  logic        us_tick;
  logic [15:0] us_div;
  logic [31:0] p_timer;
  logic [31:0] p_last;
  logic [31:0] p_edges;
  logic        p_seen;
  logic        p_ev;
  logic        p_done;

  assign p_ev = sync2[psel] & ~prev[psel];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      us_div  <= '0;
      us_tick <= 1'b0;
    end else if (us_div == 16'(CYCLES_PER_US - 1)) begin
      us_div  <= '0;
      us_tick <= 1'b1;
    end else begin
      us_div  <= us_div + 16'h0001;
      us_tick <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      p_timer <= '0;
      p_last  <= '0;
      p_edges <= '0;
      p_seen  <= 1'b0;
      p_done  <= 1'b0;
    end else if (scan_start) begin
      p_timer <= '0;
      p_edges <= '0;
      p_seen  <= 1'b0;
      p_done  <= 1'b0;
    end else if (scan_active) begin
      p_done <= 1'b0;
      if (p_ev) begin
        if (p_seen) begin
          p_last  <= p_timer;
          p_edges <= p_edges + 32'h0000_0001;
          p_done  <= 1'b1;
        end
        p_seen  <= 1'b1;
        p_timer <= '0;
      end else if (us_tick) begin
        p_timer <= p_timer + 32'h0000_0001;
      end
    end else begin
      p_done <= 1'b0;
    end
  end

  assign events = {p_done, |ovf & ~|cap_ovf, scan_start};

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] hz;
  int          ch;

  assign hz = (p_last == 32'h0000_0000) ? 32'h0000_0000
              : 32'd1_000_000 / p_last;

  always_comb begin
    ch     = 0;
    rd_mux = 32'h0000_0000;
    case (reg_req.addr)
      REG_CTRL:   rd_mux = ctrl;
      REG_SCAN:   rd_mux = {31'h0000_0000, scan_active};
      REG_STATUS: rd_mux = {29'h0000_0000, status};
      REG_MASK:   rd_mux = {29'h0000_0000, mask};
      REG_QNET:   rd_mux = q_net;
      REG_QFWD:   rd_mux = q_fwd;
      REG_QREV:   rd_mux = q_rev;
      REG_QDIR:   rd_mux = {31'h0000_0000, q_dir};
      REG_PERIOD: rd_mux = p_last;
      REG_PCOUNT: rd_mux = hz;
      REG_ITVL:   rd_mux = itvl;
      default: begin
        if (reg_req.addr >= REG_CH_BASE
            && reg_req.addr < REG_CH_BASE + 8'(4 * N_CH)) begin
          ch = int'((reg_req.addr - REG_CH_BASE) >> 2);
          case (out_sel)
            OUT_COUNT: rd_mux = cap[ch];
            OUT_FREQ:  rd_mux = freq[ch];
            OUT_AVG:   rd_mux = avg[ch];
            default:   rd_mux = cap[ch];
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      reg_rdata <= '0;
    else if (reg_req.rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= '0;
  end

endmodule

// file: ppq_checker_assertions.sv
// Concurrent checks on the ports of the pulse and quadrature block.
// Assumes requests are idle during reset; bound to the block below.
`timescale 1ns/1ns
module ppq_checker
  import ppq_pkg::*;
#(
  parameter int N_CH         = 4,
  parameter int DEBOUNCE_CNT = DEBOUNCE_CYCLES
) (
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire logic [N_CH-1:0] single_ended_inputs,
  input wire logic            enc_a,
  input wire logic            enc_b,
  input wire reg_req_t        reg_req,
  input wire logic [31:0]     reg_rdata,
  input wire logic            irq
);
  logic [ST_W-1:0] mask_q;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Shadow of the interrupt mask
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= '0;
    end else if (reg_req.wr && reg_req.addr == REG_MASK) begin
      mask_q <= reg_req.wdata[ST_W-1:0];
    end
  end

  chk_rdata_idle: assert property (
    !$past(reg_req.rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside the answer cycle");
  chk_mask_readback: assert property (
    reg_req.rd && reg_req.addr == REG_MASK
    |=> reg_rdata == 32'($past(mask_q)))
    else $error("mask reads back wrong");
  chk_irq_masked: assert property (mask_q == '0 |-> !irq)
    else $error("interrupt high with all sources masked");
  chk_scan_window: assert property (
    reg_req.wr && reg_req.addr == REG_SCAN && reg_req.wdata[0]
    ##1 reg_req.rd && reg_req.addr == REG_SCAN |=> reg_rdata[0])
    else $error("window not active after scan start");
  chk_scan_irq: assert property (
    reg_req.wr && reg_req.addr == REG_SCAN && reg_req.wdata[0]
    && mask_q[ST_SCAN] |-> ##[1:3] irq)
    else $error("scan start did not raise the interrupt");
  chk_qdir_bit: assert property (
    reg_req.rd && reg_req.addr == REG_QDIR |=> reg_rdata[31:1] == '0)
    else $error("direction word has stray bits");
  chk_itvl_live: assert property (
    reg_req.rd && reg_req.addr == REG_ITVL |=> reg_rdata != 32'h0)
    else $error("scan interval divisor reads zero");
  chk_unmapped_zero: assert property (
    reg_req.rd && reg_req.addr >= 8'h50 |=> reg_rdata == 32'h0)
    else $error("unmapped address returned data");
endmodule

bind pulse_period_quadrature_counter ppq_checker #(
  .N_CH(N_CH), .DEBOUNCE_CNT(DEBOUNCE_CNT)
) u_ppq_checker (
  .ref_clk(ref_clk), .rst_n(rst_n),
  .single_ended_inputs(single_ended_inputs),
  .enc_a(enc_a), .enc_b(enc_b), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .irq(irq)
);

// file: signal_source.sv
// Model of pulse sensors, switch contacts and a shaft encoder.
// Assumes the bench calls its tasks; pulse lines idle high by pull-up.
`timescale 1ns/1ns
module signal_source (
  input  wire logic       ref_clk,
  output      logic [3:0] pin,
  output      logic       enc_a,
  output      logic       enc_b
);
  initial begin
    pin   = 4'hF;
    enc_a = 1'b0;
    enc_b = 1'b0;
  end

  task automatic step(input logic [3:0] p, input int h);
    @(posedge ref_clk) pin <= p;
    repeat (h + 1) @(posedge ref_clk);
  endtask

  task automatic pulses(input logic [3:0] m, input int n, input int h);
    repeat (n) begin
      step(pin & ~m, h);
      step(pin | m, h);
    end
  endtask

  // Contact chatter on closing and on opening
  task automatic bounce(input logic [3:0] m);
    step(pin & ~m, 0);
    step(pin | m, 0);
    step(pin & ~m, 12);
    step(pin | m, 0);
    step(pin & ~m, 0);
    step(pin | m, 12);
  endtask

  // Phase sequence, A leading or B leading
  task automatic quad(input int n, input logic fwd);
    logic [7:0] qs;
    qs = fwd ? 8'hB4 : 8'h78;
    repeat (n) begin
      for (int j = 0; j < 4; j++) begin
        @(posedge ref_clk) {enc_a, enc_b} <= qs[7-2*j -: 2];
        repeat (4) @(posedge ref_clk);
      end
    end
    repeat (4) @(posedge ref_clk);
  endtask
endmodule

// file: pulse_period_quadrature_counter_bench.sv
// Self-checking bench for the pulse, period and quadrature block.
// Assumes the signal source model and the bound port checker.
`timescale 1ns/1ns
module pulse_period_quadrature_counter_bench;
  import ppq_pkg::*;
  logic        ref_clk   = 1'b0;
  logic        rst_n     = 1'b0;
  reg_req_t    reg_req   = '0;
  logic [3:0]  pin;
  logic        enc_a;
  logic        enc_b;
  logic [31:0] reg_rdata;
  logic        irq;
  int          fails     = 0;
  int          n_checks  = 0;
  int          cycles    = 0;

  always #5 ref_clk = ~ref_clk;

  pulse_period_quadrature_counter #(.N_CH(4), .DEBOUNCE_CNT(4))
  u_pulse_period_quadrature_counter (
    .ref_clk(ref_clk), .rst_n(rst_n), .single_ended_inputs(pin),
    .enc_a(enc_a), .enc_b(enc_b), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .irq(irq)
  );

  signal_source u_signal_source (
    .ref_clk(ref_clk), .pin(pin), .enc_a(enc_a), .enc_b(enc_b)
  );

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk) reg_req <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk) reg_req <= '0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk) reg_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk) reg_req <= '0;
    #1 chk(reg_rdata, exp);
  endtask

  // Start a scan, then read the window flag back to back
  task automatic scan;
    @(posedge ref_clk) reg_req <= '{REG_SCAN, 32'h1, 1'b1, 1'b0};
    @(posedge ref_clk) reg_req <= '{REG_SCAN, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk) reg_req <= '0;
    #1 chk(32'(reg_rdata[0]), 32'h1);
  endtask

  task automatic t_reset;
    rc(REG_CTRL, CTRL_RESET);
    rc(REG_ITVL, ITVL_RESET);
    rc(REG_MASK, 32'h0);
    rc(REG_STATUS, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rc(8'hFC, 32'h0);
    wr(REG_ITVL, 32'h0);
    rc(REG_ITVL, 32'h1);
  endtask

  task automatic t_pulse;
    wr(REG_CTRL, 32'h1);
    scan;
    wr(REG_SCAN, 32'h2);
    u_signal_source.pulses(4'h3, 5, 3);
    u_signal_source.step(4'hC, 4);
    scan;
    rc(REG_CH_BASE, 32'h5);
    rc(REG_CH_BASE + 8'h4, 32'h6);
    scan;
    rc(REG_CH_BASE, 32'h0);
    u_signal_source.step(4'hF, 4);
  endtask

  task automatic t_freq;
    wr(REG_ITVL, 32'h2);
    wr(REG_CTRL, 32'h1001);
    scan;
    u_signal_source.pulses(4'h1, 8, 3);
    scan;
    rc(REG_CH_BASE, 32'h4);
    wr(REG_CTRL, 32'h2001);
    repeat (4) scan;
    rc(REG_CH_BASE, 32'h0);
  endtask

  task automatic t_switch;
    wr(REG_ITVL, 32'h1);
    wr(REG_CTRL, 32'h40);
    scan;
    u_signal_source.bounce(4'h4);
    scan;
    rc(REG_CH_BASE + 8'h8, 32'h1);
  endtask

  task automatic t_quad;
    int k;
    for (int m = 0; m < 3; m++) begin
      k = 1 << m;
      wr(REG_CTRL, 32'(m) << CTRL_QMODE_POS);
      scan;
      u_signal_source.quad(3, 1'b1);
      rc(REG_QNET, 32'(3 * k));
      rc(REG_QFWD, 32'(3 * k));
      rc(REG_QDIR, 32'h1);
      scan;
      u_signal_source.quad(2, 1'b0);
      rc(REG_QNET, 32'(-2 * k));
      rc(REG_QREV, 32'(2 * k));
      rc(REG_QDIR, 32'h0);
    end
  endtask

  task automatic t_period;
    wr(REG_CTRL, 32'h0);
    wr(REG_SCAN, 32'h2);
    wr(REG_STATUS, 32'h7);
    u_signal_source.pulses(4'h1, 3, 99);
    rc(REG_STATUS, 32'h0);
    scan;
    u_signal_source.pulses(4'h1, 3, 99);
    rc(REG_STATUS, 32'h5);
  endtask

  task automatic t_irq;
    wr(REG_MASK, 32'h1);
    scan;
    chk(32'(irq), 32'h1);
    wr(REG_STATUS, 32'h1);
    #1 chk(32'(irq), 32'h0);
    wr(REG_MASK, 32'h0);
    rc(REG_MASK, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset;
    t_pulse;
    t_freq;
    t_switch;
    t_quad;
    t_period;
    t_irq;
    finish_test;
  end
endmodule
